/* verilog/dibs_pkg.sv */
/*
 * Package for the DMA isochronous buffer status block: register word
 * indices, reset values and field widths.
 * Assumes the APB slave decodes byte addresses with 32-bit words.
 */
package dibs_pkg;
    // Printed offsets are not all multiples of four: they are word indices
    localparam logic [15:0] IDX_CH1_WR_PTR_LOW = 16'hffb8;
    localparam logic [15:0] IDX_CH0_WR_PTR_LOW = 16'hffbc;
    localparam logic [15:0] IDX_CH0_BUF_BYTES_HIGH = 16'hffec;
    localparam logic [15:0] IDX_BULK_COUNT_HIGH = 16'hfff1;
    localparam logic [15:0] IDX_BULK_COUNT_LOW = 16'hfff2;
    localparam logic [15:0] IDX_CH1_BUF_BYTES_HIGH = 16'hfff4;
    // Companion registers named nearby
    localparam logic [15:0] IDX_CH0_BUF_BYTES_LOW = 16'hffeb;
    localparam logic [15:0] IDX_CH1_BUF_BYTES_LOW = 16'hfff3;
    localparam logic [15:0] IDX_CH0_WR_PTR_HIGH = 16'hffbb;
    localparam logic [15:0] IDX_CH1_WR_PTR_HIGH = 16'hffb7;
    localparam logic [15:0] IDX_CH0_RD_PTR_LOW = 16'hffba;
    localparam logic [15:0] IDX_CH1_RD_PTR_LOW = 16'hffb6;
    localparam logic [15:0] IDX_CH0_RD_PTR_HIGH = 16'hffb9;
    localparam logic [15:0] IDX_CH1_RD_PTR_HIGH = 16'hffb5;
    localparam int ADDR_W = 18;
    localparam int PTR_W = 11;
    localparam int CNT_W = 16;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [10:0] RST_PTR = 11'h000;
endpackage

/* verilog/dibs_status.sv */
/*
 * DMA isochronous buffer status: per-channel buffer byte count latched at
 * start-of-frame, bulk packet count, and buffer pointers, read over APB.
 * Assumes the buffer manager and DMA pulse single-cycle byte strobes and
 * that all inputs are synchronous to i_ref_clk.
 */
// What this block does
// RL1 - Report sixteen-bit buffer byte count per channel
// RL2 - Latch byte count at start-of-frame, hold frame
// RL3 - Bulk packet count, read/write, resets to zero
// RL4 - Eleven-bit write pointer, low byte readable
// RL5 - Pointer reads anytime, without side effects
// RL6 - Write pointer consistent with DMA read pointer
// RL7 - Read pointer exposed as low and high bytes
// RL8 - Occupancy is write minus read, modulo 2048
`timescale 1ns/1ps
module dibs_status (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sof,
    input wire logic [1:0] i_buf_write,
    input wire logic [1:0] i_dma_read,
    output logic [15:0] o_bulk_packet_count
);
    // Per-channel byte counters and the frame snapshot of their difference
    logic [10:0] buffer_write_pointer [2];
    logic [10:0] dma_read_pointer [2];
    logic [15:0] buf_bytes [2];
    // Software-owned bulk packet count
    logic [15:0] packet_tally;
    // Bus decode
    logic [15:0] word_idx;
    logic access_phase;
    logic read_armed;
    logic capture;
    logic bus_wr;
    logic wr_bulk_low;
    logic wr_bulk_high;
    // Read path
    logic shared_hit;
    logic [7:0] shared_rdata;
    logic hit;
    logic [7:0] next_rdata;
    logic [7:0] rdata;

    assign word_idx = i_paddr[17:2];
    assign access_phase = i_psel && i_penable;
    // The read word is taken at the first enabled edge of a transfer
    assign capture = i_clk_en && i_psel && !read_armed;
    assign bus_wr = access_phase && i_pwrite && o_pready;
    assign wr_bulk_low = bus_wr && i_pstrb[0]
        && (word_idx == dibs_pkg::IDX_BULK_COUNT_LOW);
    assign wr_bulk_high = bus_wr && i_pstrb[0]
        && (word_idx == dibs_pkg::IDX_BULK_COUNT_HIGH);

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_ch
            localparam logic [15:0] IDX_BYTES_LOW = (ch == 0)
                ? dibs_pkg::IDX_CH0_BUF_BYTES_LOW
                : dibs_pkg::IDX_CH1_BUF_BYTES_LOW;
            localparam logic [15:0] IDX_BYTES_HIGH = (ch == 0)
                ? dibs_pkg::IDX_CH0_BUF_BYTES_HIGH
                : dibs_pkg::IDX_CH1_BUF_BYTES_HIGH;
            localparam logic [15:0] IDX_WR_LOW = (ch == 0)
                ? dibs_pkg::IDX_CH0_WR_PTR_LOW
                : dibs_pkg::IDX_CH1_WR_PTR_LOW;
            localparam logic [15:0] IDX_WR_HIGH = (ch == 0)
                ? dibs_pkg::IDX_CH0_WR_PTR_HIGH
                : dibs_pkg::IDX_CH1_WR_PTR_HIGH;
            localparam logic [15:0] IDX_RD_LOW = (ch == 0)
                ? dibs_pkg::IDX_CH0_RD_PTR_LOW
                : dibs_pkg::IDX_CH1_RD_PTR_LOW;
            localparam logic [15:0] IDX_RD_HIGH = (ch == 0)
                ? dibs_pkg::IDX_CH0_RD_PTR_HIGH
                : dibs_pkg::IDX_CH1_RD_PTR_HIGH;
            logic [10:0] occupancy;
            logic hit_here;
            logic [7:0] data_here;

            // Pointers advance only on their own strobes and wrap at 2048
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    buffer_write_pointer[ch] <= dibs_pkg::RST_PTR;
                end else if (i_clk_en && i_buf_write[ch]) begin
                    buffer_write_pointer[ch] <=
                        buffer_write_pointer[ch] + 11'h001; // RL4 RL6
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    dma_read_pointer[ch] <= dibs_pkg::RST_PTR;
                end else if (i_clk_en && i_dma_read[ch]) begin
                    dma_read_pointer[ch] <=
                        dma_read_pointer[ch] + 11'h001; // RL7 RL6
                end
            end

            // Eleven-bit arithmetic handles pointer wrap without extra logic
            assign occupancy = buffer_write_pointer[ch]
                - dma_read_pointer[ch]; // RL8

            // The snapshot stays still for a whole frame so software can
            // steer its audio rate from one consistent value
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    buf_bytes[ch] <= dibs_pkg::RST_COUNT;
                end else if (i_clk_en && i_sof) begin
                    buf_bytes[ch] <= {5'h00, occupancy}; // RL2 RL1
                end
            end

            // Reads are pure decode: nothing in the datapath moves on a read
            always_comb begin
                hit_here = 1'b1;
                data_here = 8'h00;
                case (word_idx)
                    IDX_BYTES_LOW: begin
                        data_here = buf_bytes[ch][7:0]; // RL1
                    end
                    IDX_BYTES_HIGH: begin
                        data_here = buf_bytes[ch][15:8]; // RL1
                    end
                    IDX_WR_LOW: begin
                        data_here = buffer_write_pointer[ch][7:0]; // RL4 RL5
                    end
                    IDX_WR_HIGH: begin
                        data_here = {5'h00, buffer_write_pointer[ch][10:8]};
                    end
                    IDX_RD_LOW: begin
                        data_here = dma_read_pointer[ch][7:0]; // RL7
                    end
                    IDX_RD_HIGH: begin
                        data_here = {5'h00, dma_read_pointer[ch][10:8]}; // RL7
                    end
                    default: begin
                        hit_here = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // Bulk count halves live outside the per-channel map
    always_comb begin
        shared_hit = 1'b1;
        shared_rdata = 8'h00;
        case (word_idx)
            dibs_pkg::IDX_BULK_COUNT_LOW: begin
                shared_rdata = packet_tally[7:0]; // RL3
            end
            dibs_pkg::IDX_BULK_COUNT_HIGH: begin
                shared_rdata = packet_tally[15:8]; // RL3
            end
            default: begin
                shared_hit = 1'b0;
            end
        endcase
    end

    // Unselected sources give zero, so an OR merges them
    always_comb begin
        hit = shared_hit || g_ch[0].hit_here || g_ch[1].hit_here;
        next_rdata = shared_rdata | g_ch[0].data_here | g_ch[1].data_here;
    end

    // Armed once the read word is held; dropped as the transfer completes
    // so that a back-to-back setup arms again
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            read_armed <= 1'b0;
        end else if (i_clk_en) begin
            if (!i_psel || (access_phase && read_armed)) begin
                read_armed <= 1'b0;
            end else begin
                read_armed <= 1'b1;
            end
        end
    end

    // Holding the word keeps read data still through the access phase
    // even while a pointer moves underneath it
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata <= 8'h00;
        end else if (capture) begin
            rdata <= next_rdata; // RL5
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            packet_tally <= dibs_pkg::RST_COUNT; // RL3
        end else if (wr_bulk_low) begin
            packet_tally[7:0] <= i_pwdata[7:0]; // RL3
        end else if (wr_bulk_high) begin
            packet_tally[15:8] <= i_pwdata[7:0]; // RL3
        end
    end

    // No wait state while the clock enable stays high through setup and access;
    // a setup edge lost to a low enable costs one extra access cycle
    assign o_pready = i_clk_en && read_armed;
    assign o_pslverr = access_phase && !hit;
    assign o_prdata = {24'h000000, rdata};
    assign o_bulk_packet_count = packet_tally;
endmodule // dibs_status

/* dv/dibs_monitor.sv */
/* Assertions on dibs_status ports; assumes dibs_pkg is compiled first. */
`timescale 1ns/1ps
module dibs_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic [3:0] i_pstrb,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_sof,
    input wire logic [1:0] i_buf_write,
    input wire logic [1:0] i_dma_read,
    input wire logic [15:0] o_bulk_packet_count
);
    logic [10:0] sh_wr_ptr;
    logic [10:0] sh_rd_ptr;
    logic [15:0] sh_bytes;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire acc = i_psel && i_penable && o_pready;
    wire wr = acc && i_pwrite && i_pstrb[0];
    // Channel 0 reference: byte counters and the frame snapshot
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_wr_ptr <= 11'h000;
            sh_rd_ptr <= 11'h000;
            sh_bytes <= 16'h0000;
        end else if (i_clk_en) begin
            sh_wr_ptr <= sh_wr_ptr + {10'h000, i_buf_write[0]};
            sh_rd_ptr <= sh_rd_ptr + {10'h000, i_dma_read[0]};
            if (i_sof) begin
                sh_bytes <= {5'h00, sh_wr_ptr - sh_rd_ptr};
            end
        end
    end
    sequence wr_to(logic [15:0] idx);
        wr && i_paddr == {idx, 2'b00};
    endsequence
    sequence rd_held(logic [15:0] idx);
        acc && !i_pwrite && i_paddr == {idx, 2'b00} && $past(i_psel)
            && $stable(i_paddr);
    endsequence
    wr_low_a: assert property (wr_to(dibs_pkg::IDX_BULK_COUNT_LOW) |=>
        o_bulk_packet_count[7:0] == $past(i_pwdata[7:0])) else $error("low");
    wr_high_a: assert property (wr_to(dibs_pkg::IDX_BULK_COUNT_HIGH) |=>
        o_bulk_packet_count[15:8] == $past(i_pwdata[7:0])) else $error("hi");
    bulk_hold_a: assert property (!wr |=> $stable(o_bulk_packet_count))
        else $error("bulk count moved");
    upper_zero_a: assert property (acc |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    frame_stable_a: assert property (
        rd_held(dibs_pkg::IDX_CH0_BUF_BYTES_LOW)
        |-> o_prdata[7:0] == $past(sh_bytes[7:0]))
        else $error("byte count not the frame snapshot");
    ro_quiet_a: assert property (
        wr_to(dibs_pkg::IDX_CH0_BUF_BYTES_HIGH) |-> !o_pslverr)
        else $error("read-only write flagged");
    ptr_step_a: assert property (
        rd_held(dibs_pkg::IDX_CH0_WR_PTR_LOW)
        |-> o_prdata[7:0] == $past(sh_wr_ptr[7:0]))
        else $error("write pointer value wrong");
    ptr_still_a: assert property (
        rd_held(dibs_pkg::IDX_CH0_WR_PTR_LOW) |-> !o_pslverr)
        else $error("pointer read refused");
    rd_ptr_a: assert property (
        rd_held(dibs_pkg::IDX_CH0_RD_PTR_LOW)
        |-> o_prdata[7:0] == $past(sh_rd_ptr[7:0]))
        else $error("read pointer value wrong");
endmodule // dibs_monitor
bind dibs_status dibs_monitor mon (.*);

/* dv/testbench.sv */
/* Directed APB bench for dibs_status; the checker is bound separately. */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, ce = 1, sel = 0, en = 0, wr = 0, sof = 0;
    logic rdy, err, eq;
    logic [17:0] adr = 0;
    logic [31:0] wd = 0, rdat, rq;
    logic [1:0] bw = 0, dr = 0;
    logic [15:0] cnt;
    int n_errors = 0, checked = 0, cyc = 0;
    dibs_status DUT (.i_ref_clk(clk), .i_rst(rst), .i_clk_en(ce),
        .i_psel(sel), .i_penable(en), .i_pwrite(wr), .i_paddr(adr),
        .i_pwdata(wd), .i_pstrb(4'hf), .o_prdata(rdat), .o_pready(rdy),
        .o_pslverr(err), .i_sof(sof), .i_buf_write(bw), .i_dma_read(dr),
        .o_bulk_packet_count(cnt));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin
        n_errors++;
        final_report;
    end
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        checked++;
        if (got !== ex) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic xfer(logic w, logic [15:0] idx, logic [7:0] d);
        @(posedge clk) {sel, wr, adr, wd} <= {1'b1, w, idx, 2'b00, 24'h0, d};
        @(posedge clk) en <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        {rq, eq} = {rdat, err};
        {sel, en} <= 2'b00;
    endtask
    // Strobe word for pulse is {sof, buf_write[1:0], dma_read[1:0]}
    task automatic pulse(int n, logic [4:0] s);
        repeat (n) begin
            @(posedge clk) {sof, bw, dr} <= s;
            @(posedge clk) {sof, bw, dr} <= 5'h00;
        end
    endtask
    task final_report;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        xfer(0, dibs_pkg::IDX_BULK_COUNT_HIGH, 8'h00);
        chk("bulk high", 32'h0, rq);
        xfer(0, dibs_pkg::IDX_CH0_BUF_BYTES_HIGH, 8'h00);
        chk("bytes high", 32'h0, rq);
        xfer(1, dibs_pkg::IDX_BULK_COUNT_LOW, 8'h5a);
        xfer(1, dibs_pkg::IDX_BULK_COUNT_HIGH, 8'ha5);
        @(posedge clk);
        chk("bulk count", 32'ha55a, cnt);
        xfer(0, dibs_pkg::IDX_BULK_COUNT_LOW, 8'h00);
        chk("bulk low", 32'h5a, rq);
        xfer(1, dibs_pkg::IDX_CH0_BUF_BYTES_HIGH, 8'hff);
        chk("ro write", 32'h0, eq);
        xfer(0, dibs_pkg::IDX_CH0_BUF_BYTES_HIGH, 8'h00);
        chk("ro kept", 32'h0, rq);
        xfer(0, 16'h0000, 8'h00);
        chk("unmapped", 32'h1, eq);
        chk("unmapped data", 32'h0, rq);
        pulse(5, 5'h04);
        pulse(2, 5'h01);
        pulse(1, 5'h10);
        xfer(0, dibs_pkg::IDX_CH0_BUF_BYTES_LOW, 8'h00);
        chk("bytes low", 32'h3, rq);
        pulse(1, 5'h04);
        xfer(0, dibs_pkg::IDX_CH0_WR_PTR_LOW, 8'h00);
        chk("wr ptr0", 32'h6, rq);
        xfer(0, dibs_pkg::IDX_CH0_WR_PTR_LOW, 8'h00);
        chk("wr ptr0 again", 32'h6, rq);
        xfer(0, dibs_pkg::IDX_CH0_BUF_BYTES_LOW, 8'h00);
        chk("bytes held", 32'h3, rq);
        xfer(0, dibs_pkg::IDX_CH0_RD_PTR_LOW, 8'h00);
        chk("rd ptr0", 32'h2, rq);
        pulse(3, 5'h08);
        pulse(1, 5'h02);
        pulse(1, 5'h10);
        xfer(0, dibs_pkg::IDX_CH1_BUF_BYTES_LOW, 8'h00);
        chk("bytes ch1", 32'h2, rq);
        xfer(0, dibs_pkg::IDX_CH1_WR_PTR_LOW, 8'h00);
        chk("wr ptr1", 32'h3, rq);
        xfer(0, dibs_pkg::IDX_CH1_RD_PTR_LOW, 8'h00);
        chk("rd ptr1", 32'h1, rq);
        xfer(0, dibs_pkg::IDX_CH0_BUF_BYTES_LOW, 8'h00);
        chk("bytes new frame", 32'h4, rq);
        @(posedge clk) ce <= 1'b0;
        pulse(2, 5'h04);
        @(posedge clk) ce <= 1'b1;
        xfer(0, dibs_pkg::IDX_CH0_WR_PTR_LOW, 8'h00);
        chk("frozen ptr", 32'h6, rq);
        final_report;
    end
endmodule // testbench
